// File: mrt_core.sv
// register file transfer micro-command execution with AHB-Lite access
// Summary of operation
// - load D with complemented file output
// - D byte in E1 starts byte write
// - address bit 15 selects written byte lane
// - write address from S, protection checked
// - true: Bu file, Au fan-in, clear carry
// - read cycle E1-E3 hold, repeat to E4
// - complement: Bu inverted file, carry set
// - index clears Bu when low bits zero
// - index loads Au, clears carry, holds
// - index arms segment tag on next write
// - false: Au inverted fan-in, carry set
// - stores after address load are read-related
// - upper immediate: left byte, right kept
// - lower immediate: right byte, left cleared
// - spare bits only count in parity
`timescale 1ns/1ps
module mrt_core (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic [15:0] MS_RDATA,
	input wire logic PROT_FAULT,
	output mrt_pkg::mrt_ms_req_t MS_REQ,
	output logic [3:0] S_TAG
);

	// ****************************************
	// storage and state
	// ****************************************
	logic [15:0] rf_mem [0:31];
	logic [3:0] tag_mem [0:31];
	mrt_pkg::mrt_state_t st_r;
	mrt_pkg::mrt_state_t st_nxt;

	logic [2:0] minor;
	logic minor_last;
	logic exec_go;
	logic fresh_go;
	logic [15:0] ex_cmd;
	mrt_pkg::mrt_kind_t kind;
	logic [4:0] rn;
	logic [15:0] rf_rd;
	logic [3:0] tag_rd;
	logic [15:0] fanin;
	logic accept;
	logic wr_phase;
	logic hready_c;
	logic rf_we;
	logic [4:0] rf_wa;
	logic [15:0] rf_wd;
	logic tag_we;
	logic [3:0] tag_wd;
	logic hold_start;
	logic [2:0] hold_lim;
	logic write_start;
	logic [1:0] start_be;
	logic [31:0] status_w;
	localparam int RF_TAG_HI = mrt_pkg::RF_TAG_LSB + 3;

	mrt_minor_seq u_seq (
		.clk(CORE_CLK),
		.rst(RST),
		.advance(exec_go),
		.minor(minor),
		.last(minor_last)
	);

	// ****************************************
	// command source and operands
	// ****************************************
	// held commands win over software; a bus write data phase is stalled meanwhile
	assign wr_phase = (st_r.ph == mrt_pkg::PH_WRITE);
	assign hready_c = !(st_r.ph == mrt_pkg::PH_RD_WAIT) &&
		!(wr_phase && st_r.hold);
	assign accept = HSEL && HTRANS[1] && HREADY;
	assign fresh_go = wr_phase && !st_r.hold && st_r.hit &&
		(st_r.idx == mrt_pkg::IDX_CMD);
	assign exec_go = st_r.hold || fresh_go;
	assign ex_cmd = st_r.hold ? st_r.hold_cmd : HWDATA[15:0];
	assign kind = exec_go ? mrt_pkg::mrt_decode(ex_cmd) : mrt_pkg::K_NONE;
	assign rn = ex_cmd[4:0];
	assign rf_rd = rf_mem[rn];
	assign tag_rd = tag_mem[rn];
	// storage data replaces D on the fan-in from E4
	assign fanin = (st_r.rd_cyc && (minor >= mrt_pkg::MINOR_E4)) ?
		MS_RDATA : st_r.d;

	assign status_w = {21'h00_0000, st_r.tag_pend, st_r.prot_err,
		st_r.par_err, st_r.fc, st_r.hold, st_r.wr_act, st_r.ro_ref,
		st_r.rd_cyc, minor};

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		rf_we = 1'b0;
		rf_wa = rn;
		rf_wd = fanin;
		tag_we = 1'b0;
		tag_wd = st_r.tag_val;
		hold_start = 1'b0;
		hold_lim = mrt_pkg::MINOR_E4;
		write_start = 1'b0;
		start_be = 2'b11;

		// bus data phase
		case (st_r.ph)
			mrt_pkg::PH_RD_WAIT: begin
				st_nxt.ph = mrt_pkg::PH_RD_DONE;
				st_nxt.rdata = 32'h0000_0000;
				if (st_r.hit && (st_r.idx[6:5] == mrt_pkg::IDX_RF_TOP)) begin
					st_nxt.rdata = {12'h000, tag_mem[st_r.idx[4:0]],
						rf_mem[st_r.idx[4:0]]};
				end else if (st_r.hit) begin
					case (st_r.idx)
						mrt_pkg::IDX_CMD: st_nxt.rdata = {16'h0000, st_r.cmd_last};
						mrt_pkg::IDX_STATUS: st_nxt.rdata = status_w;
						mrt_pkg::IDX_CTRL: st_nxt.rdata = {30'h0000_0000,
							st_r.feat_prot, st_r.feat_reloc};
						mrt_pkg::IDX_SREG: st_nxt.rdata = {12'h000, st_r.s_tag,
							st_r.s};
						mrt_pkg::IDX_DREG: st_nxt.rdata = {16'h0000, st_r.d};
						mrt_pkg::IDX_AREG: st_nxt.rdata = {16'h0000, st_r.a};
						mrt_pkg::IDX_BREG: st_nxt.rdata = {16'h0000, st_r.b};
						default: st_nxt.rdata = 32'h0000_0000;
					endcase
				end
			end
			mrt_pkg::PH_WRITE: begin
				if (hready_c && st_r.hit) begin
					if (st_r.idx[6:5] == mrt_pkg::IDX_RF_TOP) begin
						rf_we = 1'b1;
						rf_wa = st_r.idx[4:0];
						rf_wd = HWDATA[15:0];
						tag_we = 1'b1;
						tag_wd = HWDATA[RF_TAG_HI:mrt_pkg::RF_TAG_LSB];
					end else if (st_r.idx == mrt_pkg::IDX_CTRL) begin
						st_nxt.feat_reloc = HWDATA[mrt_pkg::CTRL_RELOC];
						st_nxt.feat_prot = HWDATA[mrt_pkg::CTRL_PROT];
					end else if (st_r.idx == mrt_pkg::IDX_STATUS) begin
						// write one to clear; a new event below overrides
						if (HWDATA[mrt_pkg::STAT_PAR_ERR]) begin
							st_nxt.par_err = 1'b0;
						end
						if (HWDATA[mrt_pkg::STAT_PROT_ERR]) begin
							st_nxt.prot_err = 1'b0;
						end
					end
				end
			end
			default: begin
			end
		endcase
		if (hready_c) begin
			st_nxt.ph = !accept ? mrt_pkg::PH_IDLE :
				(HWRITE ? mrt_pkg::PH_WRITE : mrt_pkg::PH_RD_WAIT);
			if (accept) begin
				st_nxt.hit = (HADDR[31:9] == 23'h00_0000);
				st_nxt.idx = HADDR[8:2];
			end
		end

		if (fresh_go) begin
			st_nxt.cmd_last = ex_cmd;
			// every bit counts in odd parity, spares included
			if (!(^ex_cmd)) begin
				st_nxt.par_err = 1'b1;
			end
		end

		// command execution
		case (kind)
			mrt_pkg::K_SA_LOAD: begin
				st_nxt.a = rf_rd;
				case (ex_cmd[11:10])
					2'b00: st_nxt.b = mrt_pkg::B_PLUS_ONE;
					2'b01: st_nxt.b = mrt_pkg::B_MINUS_ONE;
					2'b10: st_nxt.b = mrt_pkg::B_PLUS_TWO;
					default: st_nxt.b = mrt_pkg::B_MINUS_TWO;
				endcase
				st_nxt.fc = !ex_cmd[10];
				// storage addressing decided only in E0
				if (minor == mrt_pkg::MINOR_E0) begin
					st_nxt.s = rf_rd;
					st_nxt.rd_cyc = 1'b1;
					st_nxt.sa_at_e0 = 1'b1;
					st_nxt.ro_ref = (rn[4:1] == mrt_pkg::RO_REGNUM_HI);
					if (st_r.feat_reloc) begin
						st_nxt.s_tag = tag_rd;
						st_nxt.sa_tag = tag_rd;
					end
				end
			end
			mrt_pkg::K_LOAD_D: begin
				st_nxt.d = rf_rd;
				write_start = 1'b1;
			end
			mrt_pkg::K_LOAD_D_COMP: begin
				st_nxt.d = ~rf_rd;
				write_start = 1'b1;
			end
			mrt_pkg::K_LOAD_D_BYTE: begin
				st_nxt.d = rf_rd;
				write_start = 1'b1;
				// address bit 15 picks the lane
				start_be = st_r.s[0] ? 2'b01 : 2'b10;
			end
			mrt_pkg::K_A_TRUE: begin
				st_nxt.b = rf_rd;
				st_nxt.a = fanin;
				st_nxt.fc = 1'b0;
				hold_start = 1'b1;
			end
			mrt_pkg::K_A_COMP: begin
				st_nxt.b = ~rf_rd;
				st_nxt.a = fanin;
				st_nxt.fc = 1'b1;
				hold_start = 1'b1;
			end
			mrt_pkg::K_INDEX: begin
				// zero low register bits clear Bu
				st_nxt.b = (rn[2:0] == 3'h0) ? 16'h0000 : rf_rd;
				st_nxt.a = fanin;
				st_nxt.fc = 1'b0;
				hold_start = 1'b1;
				// arm tag for the next microcoded write
				if (st_r.feat_reloc) begin
					st_nxt.tag_pend = 1'b1;
					st_nxt.tag_val = (rn[2:0] == 3'h0) ? st_r.sa_tag : tag_rd;
				end
			end
			mrt_pkg::K_A_FALSE: begin
				st_nxt.b = rf_rd;
				st_nxt.a = ~fanin;
				st_nxt.fc = 1'b1;
				hold_start = 1'b1;
			end
			mrt_pkg::K_STORE_WORD, mrt_pkg::K_STORE_BYTE: begin
				rf_we = 1'b1;
				rf_wa = rn;
				rf_wd = fanin;
				if (kind == mrt_pkg::K_STORE_BYTE) begin
					// lane chosen by address bit 15, left zeroed
					rf_wd = {8'h00, st_r.s[0] ? fanin[7:0] : fanin[15:8]};
				end
				hold_start = 1'b1;
				hold_lim = mrt_pkg::MINOR_E5;
				if (st_r.tag_pend) begin
					tag_we = 1'b1;
					tag_wd = st_r.tag_val;
					st_nxt.tag_pend = 1'b0;
				end
			end
			mrt_pkg::K_IMM_UPPER: begin
				st_nxt.b = {mrt_pkg::mrt_imm(ex_cmd), st_r.b[7:0]};
			end
			mrt_pkg::K_IMM_LOWER: begin
				st_nxt.b = {8'h00, mrt_pkg::mrt_imm(ex_cmd)};
			end
			default: begin
			end
		endcase

		// write begins only in E1 right after an E0 address load
		if (write_start && (minor == mrt_pkg::MINOR_E1) && st_r.sa_at_e0) begin
			st_nxt.rd_cyc = 1'b0;
			// protection may refuse the write at S
			if ((st_r.feat_prot || st_r.feat_reloc) && PROT_FAULT) begin
				st_nxt.prot_err = 1'b1;
			end else begin
				st_nxt.wr_act = 1'b1;
				st_nxt.be = start_be;
			end
		end

		// read-related once an address load opened the read
		// first decode in E1..E3 is held through E4
		// stores first decoded in E1..E4 held through E5
		if (hold_start && !st_r.hold && st_r.rd_cyc &&
			(minor >= mrt_pkg::MINOR_E1) && (minor < hold_lim)) begin
			st_nxt.hold = 1'b1;
			st_nxt.hold_cmd = ex_cmd;
			st_nxt.hold_until = hold_lim;
		end
		if (st_r.hold && (minor == st_r.hold_until)) begin
			st_nxt.hold = 1'b0;
		end

		if (exec_go && minor_last) begin
			st_nxt.rd_cyc = 1'b0;
			st_nxt.ro_ref = 1'b0;
			st_nxt.wr_act = 1'b0;
			st_nxt.sa_at_e0 = 1'b0;
			st_nxt.hold = 1'b0;
		end

		// write data follows D; microcode leaves D alone E2..E7
		st_nxt.wdata = (st_nxt.be == 2'b11) ? st_nxt.d :
			{st_nxt.d[7:0], st_nxt.d[7:0]};
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st_r <= '0;
			st_r.ph <= mrt_pkg::PH_IDLE;
			st_r.cmd_last <= mrt_pkg::RST_WORD;
			st_r.d <= mrt_pkg::RST_WORD;
			st_r.be <= 2'b11;
		end else begin
			st_r <= st_nxt;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (rf_we) begin
			rf_mem[rf_wa] <= rf_wd;
		end
		if (tag_we) begin
			tag_mem[rf_wa] <= tag_wd;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign HRDATA = st_r.rdata;
	assign HREADYOUT = hready_c;
	assign HRESP = 1'b0;
	assign MS_REQ.wr = st_r.wr_act;
	assign MS_REQ.rd = st_r.rd_cyc;
	assign MS_REQ.ro = st_r.ro_ref;
	assign MS_REQ.be = st_r.be;
	assign MS_REQ.addr = st_r.s;
	assign MS_REQ.wdata = st_r.wdata;
	assign S_TAG = st_r.s_tag;

endmodule : mrt_core

// File: mrt_core_properties.sv
// port-level assertions for the micro-command transfer block
`timescale 1ns/1ps
module mrt_core_properties (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic PROT_FAULT,
	input wire mrt_pkg::mrt_ms_req_t MS_REQ
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	// ****************************************
	// bus and storage request checks
	// ****************************************
	a_resp_okay: assert property (HRESP == 1'b0)
		else $error("bus response not okay");
	a_reset_idle: assert property ($past(RST) |-> HREADYOUT && !MS_REQ.wr)
		else $error("not idle after reset");
	a_read_wait: assert property (HSEL && HTRANS[1] && HREADY && !HWRITE
		|=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	// a hold must release the bus within its repeat span
	a_hold_bound: assert property ($fell(HREADYOUT) |-> ##[1:6] HREADYOUT)
		else $error("bus stalled too long");
	a_byte_lane: assert property (MS_REQ.wr && MS_REQ.be != 2'b11
		|-> MS_REQ.be == (MS_REQ.addr[0] ? 2'b01 : 2'b10))
		else $error("byte lane does not follow address bit");
	a_byte_dup: assert property (MS_REQ.wr && MS_REQ.be != 2'b11
		|-> MS_REQ.wdata[15:8] == MS_REQ.wdata[7:0])
		else $error("byte write data not duplicated");
	a_addr_stable: assert property (MS_REQ.wr && $past(MS_REQ.wr)
		|-> $stable(MS_REQ.addr) && $stable(MS_REQ.be))
		else $error("write address moved during write");
	a_prot_blocks: assert property ($rose(MS_REQ.wr) |-> !$past(PROT_FAULT))
		else $error("write started on protected address");
	a_rd_excl: assert property (MS_REQ.wr |-> !MS_REQ.rd)
		else $error("read and write active together");
endmodule : mrt_core_properties

bind mrt_core mrt_core_properties i_props (
	.CORE_CLK(CORE_CLK),
	.RST(RST),
	.HSEL(HSEL),
	.HTRANS(HTRANS),
	.HWRITE(HWRITE),
	.HREADY(HREADY),
	.HREADYOUT(HREADYOUT),
	.HRESP(HRESP),
	.PROT_FAULT(PROT_FAULT),
	.MS_REQ(MS_REQ)
);

// File: mrt_minor_seq.sv
// minor cycle sequencer E0..E7 of one major cycle
`timescale 1ns/1ps
module mrt_minor_seq (
	input wire logic clk,
	input wire logic rst,
	input wire logic advance,
	output logic [2:0] minor,
	output logic last
);

	typedef struct packed {
		logic [2:0] minor;
	} mrt_seq_state_t;

	mrt_seq_state_t st_r;
	mrt_seq_state_t st_nxt;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_nxt = st_r;
		if (advance) begin
			st_nxt.minor = 3'(st_r.minor + 3'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_r.minor <= mrt_pkg::MINOR_E0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign minor = st_r.minor;
	assign last = (st_r.minor == mrt_pkg::MINOR_E7);

endmodule : mrt_minor_seq

// File: mrt_pkg.sv
// shared constants, types and command decode for the micro-command block
package mrt_pkg;

	// ****************************************
	// register map (byte offsets, word index)
	// ****************************************
	localparam logic [6:0] IDX_CMD = 7'h00;
	localparam logic [6:0] IDX_STATUS = 7'h01;
	localparam logic [6:0] IDX_CTRL = 7'h02;
	localparam logic [6:0] IDX_SREG = 7'h03;
	localparam logic [6:0] IDX_DREG = 7'h04;
	localparam logic [6:0] IDX_AREG = 7'h05;
	localparam logic [6:0] IDX_BREG = 7'h06;
	localparam logic [1:0] IDX_RF_TOP = 2'h1;
	localparam logic [31:0] OFS_RF_BASE = 32'h0000_0080;

	// ****************************************
	// field positions
	// ****************************************
	localparam int STAT_PAR_ERR = 8;
	localparam int STAT_PROT_ERR = 9;
	localparam int CTRL_RELOC = 0;
	localparam int CTRL_PROT = 1;
	localparam int RF_TAG_LSB = 16;

	// ****************************************
	// minor cycles and constants
	// ****************************************
	localparam logic [2:0] MINOR_E0 = 3'h0;
	localparam logic [2:0] MINOR_E1 = 3'h1;
	localparam logic [2:0] MINOR_E3 = 3'h3;
	localparam logic [2:0] MINOR_E4 = 3'h4;
	localparam logic [2:0] MINOR_E5 = 3'h5;
	localparam logic [2:0] MINOR_E7 = 3'h7;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] B_PLUS_ONE = 16'h0000;
	localparam logic [15:0] B_MINUS_ONE = 16'hFFFF;
	localparam logic [15:0] B_PLUS_TWO = 16'h0001;
	localparam logic [15:0] B_MINUS_TWO = 16'hFFFE;
	localparam logic [3:0] RO_REGNUM_HI = 4'hF;

	// ****************************************
	// opcodes, command bits 00..05 = word [15:10], immediate ones 00..03 = [15:12]
	// ****************************************
	localparam logic [5:0] OP_SA_PLUS1 = 6'h0C;
	localparam logic [5:0] OP_SA_MINUS1 = 6'h0D;
	localparam logic [5:0] OP_SA_PLUS2 = 6'h0E;
	localparam logic [5:0] OP_SA_MINUS2 = 6'h0F;
	localparam logic [5:0] OP_LOAD_D = 6'h1C;
	localparam logic [5:0] OP_LOAD_D_COMP = 6'h1D;
	localparam logic [5:0] OP_LOAD_D_BYTE = 6'h1E;
	localparam logic [5:0] OP_A_TRUE = 6'h30;
	localparam logic [5:0] OP_A_COMP = 6'h31;
	localparam logic [5:0] OP_INDEX = 6'h32;
	localparam logic [5:0] OP_A_FALSE = 6'h33;
	localparam logic [5:0] OP_STORE_WORD = 6'h10;
	localparam logic [5:0] OP_STORE_BYTE = 6'h11;
	localparam logic [3:0] OP_IMM_UPPER = 4'hA;
	localparam logic [3:0] OP_IMM_LOWER = 4'hB;

	typedef enum logic [3:0] {
		K_NONE = 4'b0000, K_SA_LOAD = 4'b0001, K_LOAD_D = 4'b0010,
		K_LOAD_D_COMP = 4'b0011, K_LOAD_D_BYTE = 4'b0100,
		K_A_TRUE = 4'b0101, K_A_COMP = 4'b0110, K_INDEX = 4'b0111,
		K_A_FALSE = 4'b1000, K_STORE_WORD = 4'b1001,
		K_STORE_BYTE = 4'b1010, K_IMM_UPPER = 4'b1011,
		K_IMM_LOWER = 4'b1100
	} mrt_kind_t;

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00, PH_WRITE = 2'b01, PH_RD_WAIT = 2'b10,
		PH_RD_DONE = 2'b11
	} mrt_phase_t;

	// storage write/read request toward main storage or register option
	typedef struct packed {
		logic wr;
		logic rd;
		logic ro;
		logic [1:0] be;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mrt_ms_req_t;

	typedef struct packed {
		mrt_phase_t ph;
		logic hit;
		logic [6:0] idx;
		logic [31:0] rdata;
		logic [15:0] cmd_last;
		logic [15:0] s;
		logic [3:0] s_tag;
		logic [15:0] d;
		logic [15:0] a;
		logic [15:0] b;
		logic fc;
		logic rd_cyc;
		logic ro_ref;
		logic wr_act;
		logic sa_at_e0;
		logic [1:0] be;
		logic [15:0] wdata;
		logic hold;
		logic [15:0] hold_cmd;
		logic [2:0] hold_until;
		logic par_err;
		logic prot_err;
		logic tag_pend;
		logic [3:0] tag_val;
		logic [3:0] sa_tag;
		logic feat_reloc;
		logic feat_prot;
	} mrt_state_t;

	function automatic mrt_kind_t mrt_decode(input logic [15:0] cmd);
		mrt_kind_t k;
		k = K_NONE;
		case (cmd[15:10])
			OP_SA_PLUS1, OP_SA_MINUS1, OP_SA_PLUS2, OP_SA_MINUS2: k = K_SA_LOAD;
			OP_LOAD_D: k = K_LOAD_D;
			OP_LOAD_D_COMP: k = K_LOAD_D_COMP;
			OP_LOAD_D_BYTE: k = K_LOAD_D_BYTE;
			OP_A_TRUE: k = K_A_TRUE;
			OP_A_COMP: k = K_A_COMP;
			OP_INDEX: k = K_INDEX;
			OP_A_FALSE: k = K_A_FALSE;
			OP_STORE_WORD: k = K_STORE_WORD;
			OP_STORE_BYTE: k = K_STORE_BYTE;
			default: begin
				if (cmd[15:12] == OP_IMM_UPPER) begin
					k = K_IMM_UPPER;
				end else if (cmd[15:12] == OP_IMM_LOWER) begin
					k = K_IMM_LOWER;
				end
			end
		endcase
		return k;
	endfunction : mrt_decode

	// immediate byte: bits 04..07 then bits 12..15
	function automatic logic [7:0] mrt_imm(input logic [15:0] cmd);
		return {cmd[11:8], cmd[3:0]};
	endfunction : mrt_imm

endpackage : mrt_pkg

// File: mrt_storage_model.sv
// main storage and protection model at the storage request port
`timescale 1ns/1ps
module mrt_storage_model (
	input wire logic clk,
	input wire mrt_pkg::mrt_ms_req_t req,
	input wire logic [15:0] deny_addr,
	output logic [15:0] rdata,
	output logic fault,
	output logic [15:0] wr_addr,
	output logic [15:0] wr_data,
	output logic [1:0] wr_be,
	output logic [7:0] wr_count
);
	logic wr_seen;
	initial begin
		rdata = 16'h0000;
		wr_seen = 1'b0;
		wr_count = 8'h00;
	end
	// data only in a read cycle, toggling otherwise so stale data shows
	always @(posedge clk) begin
		if (req.rd) begin
			rdata <= req.addr ^ 16'h5A5A;
		end else begin
			rdata <= ~rdata;
		end
	end
	// protection judges the address held in the request
	assign fault = (req.addr == deny_addr);
	// record each write once as it starts
	always @(posedge clk) begin
		wr_seen <= req.wr;
		if (req.wr && !wr_seen) begin
			wr_count <= wr_count + 8'h01;
			wr_addr <= req.addr;
			wr_data <= req.wdata;
			wr_be <= req.be;
		end
	end
endmodule : mrt_storage_model

// File: test_microcmd_regfile_transfer.sv
// self-checking bench for the micro-command transfer block
`timescale 1ns/1ps
module test_microcmd_regfile_transfer;
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic HSEL = 1'b1;
	logic [31:0] HADDR = 32'h0000_0000;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [31:0] HWDATA = 32'h0000_0000;
	logic [31:0] HRDATA;
	logic HREADYOUT;
	logic HRESP;
	logic [15:0] MS_RDATA;
	logic PROT_FAULT;
	mrt_pkg::mrt_ms_req_t MS_REQ;
	logic [3:0] S_TAG;
	logic [15:0] deny_addr = 16'h0202;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	logic [1:0] wr_be;
	logic [7:0] wr_count;
	logic [31:0] rv;
	int failures = 0;
	int total_checks = 0;

	mrt_core i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL),
		.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .MS_RDATA(MS_RDATA),
		.PROT_FAULT(PROT_FAULT), .MS_REQ(MS_REQ), .S_TAG(S_TAG));
	mrt_storage_model i_mem (.clk(CORE_CLK), .req(MS_REQ),
		.deny_addr(deny_addr), .rdata(MS_RDATA), .fault(PROT_FAULT),
		.wr_addr(wr_addr), .wr_data(wr_data), .wr_be(wr_be),
		.wr_count(wr_count));

	initial begin
		forever #2.5 CORE_CLK = ~CORE_CLK;
	end

	// ****************************************
	// bus tasks
	// ****************************************
	task automatic summarize;
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait for hready sampled high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		@(posedge CORE_CLK);
		while (HREADYOUT !== 1'b1) begin
			n++;
			if (n > 50) begin
				failures++;
				$display("[FAIL] %0t bus wait timed out", $time);
				summarize();
			end
			@(posedge CORE_CLK);
		end
	endtask : wait_ready
	task automatic bus(input logic w, input logic [31:0] a,
		input logic [31:0] wd);
		HADDR <= a;
		HTRANS <= 2'b10;
		HWRITE <= w;
		wait_ready();
		HTRANS <= 2'b00;
		HWDATA <= wd;
		wait_ready();
		rv = HRDATA;
	endtask : bus
	function automatic logic [31:0] ra(input logic [6:0] i);
		return {23'h0, i, 2'b00};
	endfunction : ra
	function automatic logic [31:0] rf(input logic [4:0] n);
		return mrt_pkg::OFS_RF_BASE + {25'h0, n, 2'b00};
	endfunction : rf
	function automatic logic [15:0] mk(input logic [5:0] op,
		input logic [4:0] r);
		return {op, 5'h00, r};
	endfunction : mk
	task automatic cmd(input logic [15:0] c);
		bus(1'b1, ra(mrt_pkg::IDX_CMD), {16'h0000, c});
	endtask : cmd
	task automatic rd(input logic [6:0] i);
		bus(1'b0, ra(i), 32'h0000_0000);
	endtask : rd
	// no-op commands up to the next E0; D is left alone meanwhile
	task automatic sync;
		rd(mrt_pkg::IDX_STATUS);
		repeat ((8 - rv[2:0]) % 8) cmd(16'h0000);
	endtask : sync
	task automatic alu(input logic [15:0] c, input logic [15:0] ea,
		input logic [15:0] eb, input logic ef);
		cmd(c);
		rd(mrt_pkg::IDX_AREG);
		chk(rv[15:0], ea);
		rd(mrt_pkg::IDX_BREG);
		chk(rv[15:0], eb);
		rd(mrt_pkg::IDX_STATUS);
		chk({15'h0, rv[7]}, {15'h0, ef});
	endtask : alu

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [15:0] sv;
		logic [7:0] n0;
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		bus(1'b1, ra(mrt_pkg::IDX_CTRL), 32'h0000_0003);
		// tag 6 on r5 is what the second index arms for the next store
		bus(1'b1, rf(5), 32'h0006_1234);
		bus(1'b1, rf(7), 32'h0000_00A5);
		cmd(mk(mrt_pkg::OP_LOAD_D_COMP, 5'd5));
		rd(mrt_pkg::IDX_DREG);
		chk(rv[15:0], 16'hEDCB);
		alu(mk(mrt_pkg::OP_A_TRUE, 5'd5), 16'hEDCB, 16'h1234, 1'b0);
		alu(mk(mrt_pkg::OP_A_COMP, 5'd5), 16'hEDCB, 16'hEDCB, 1'b1);
		alu(mk(mrt_pkg::OP_A_FALSE, 5'd5), 16'h1234, 16'h1234, 1'b1);
		alu(mk(mrt_pkg::OP_INDEX, 5'd8), 16'hEDCB, 16'h0000, 1'b0);
		alu(mk(mrt_pkg::OP_INDEX, 5'd5), 16'hEDCB, 16'h1234, 1'b0);
		// spare bits 7:4 set on the upper load must not matter
		bus(1'b1, ra(mrt_pkg::IDX_STATUS), 32'h0000_0100);
		alu(16'hAA7B, 16'hEDCB, 16'hAB34, 1'b0);
		// spares counted: whole word has even parity, so the flag is set
		chk({15'h0, rv[8]}, 16'h0001);
		bus(1'b1, ra(mrt_pkg::IDX_STATUS), 32'h0000_0100);
		alu(16'hB50C, 16'hEDCB, 16'h005C, 1'b0);
		chk({15'h0, rv[8]}, 16'h0000);
		// left lane, right lane, then a protected address
		for (int i = 0; i < 3; i++) begin
			sv = (i == 0) ? 16'h0100 : (i == 1) ? 16'h0101 : 16'h0202;
			bus(1'b1, rf(6), {16'h0000, sv});
			sync();
			n0 = wr_count;
			cmd(mk(mrt_pkg::OP_SA_PLUS1, 5'd6));
			cmd(mk(mrt_pkg::OP_LOAD_D_BYTE, 5'd7));
			rd(mrt_pkg::IDX_STATUS);
			chk({8'h00, wr_count - n0}, (i < 2) ? 16'h0001 : 16'h0000);
			if (i < 2) begin
				chk(wr_addr, sv);
				chk({14'h0, wr_be}, {14'h0, sv[0] ? 2'b01 : 2'b10});
				chk(wr_data, 16'hA5A5);
			end else begin
				chk({15'h0, rv[9]}, 16'h0001);
			end
			sync();
			// the closing command's effect settles only after this edge
			@(posedge CORE_CLK);
			chk({15'h0, MS_REQ.wr}, 16'h0000);
		end
		// read cycle: A-true decoded at E2 repeats up to E4
		bus(1'b1, rf(6), 32'h0003_0100);
		sync();
		cmd(mk(mrt_pkg::OP_SA_PLUS1, 5'd6));
		cmd(16'h0000);
		cmd(mk(mrt_pkg::OP_A_TRUE, 5'd5));
		// reads are not stalled by a hold: let the E3 and E4 repeats finish
		repeat (2) @(posedge CORE_CLK);
		rd(mrt_pkg::IDX_AREG);
		chk(rv[15:0], 16'h5B5A);
		rd(mrt_pkg::IDX_STATUS);
		chk({9'h0, rv[6:0]}, 16'h000D);
		chk({12'h0, S_TAG}, 16'h0003);
		// stores tied to the read: word held to E5, byte at E6
		sync();
		cmd(mk(mrt_pkg::OP_SA_PLUS1, 5'd6));
		cmd(mk(mrt_pkg::OP_STORE_WORD, 5'd9));
		cmd(mk(mrt_pkg::OP_STORE_BYTE, 5'd10));
		bus(1'b0, rf(9), 32'h0000_0000);
		chk(rv[15:0], 16'h5B5A);
		chk({12'h0, rv[19:16]}, 16'h0006);
		bus(1'b0, rf(10), 32'h0000_0000);
		chk(rv[15:0], 16'h005B);
		summarize();
	end
endmodule : test_microcmd_regfile_transfer
